// ### common/i2csf_pkg.sv
// Package of offsets, field positions and reset values for the status flag block
package i2csf_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_STATUS  = 4'h3;
    localparam logic [3:0] IDX_DATA    = 4'h4;
    localparam logic [3:0] IDX_CTRL1   = 4'h2;
    localparam logic [3:0] IDX_CTRL2   = 4'h5;
    localparam logic [3:0] IDX_ADDR1   = 4'h1;
    localparam logic [3:0] IDX_RANGE   = 4'h6;
    localparam logic [3:0] IDX_SECOND  = 4'h7;
    localparam logic [3:0] IDX_OPTIONS = 4'h8;
    localparam logic [3:0] IDX_EVSTAT  = 4'h9;
    localparam logic [3:0] IDX_EVMASK  = 4'ha;
    // ------------------------------------------------------------
    // Status register field positions
    // ------------------------------------------------------------
    localparam int BIT_DONE   = 7;
    localparam int BIT_ADDRD  = 6;
    localparam int BIT_BUSY   = 5;
    localparam int BIT_ARBITRATION_LOST_FLAG   = 4;
    localparam int BIT_RANGE  = 3;
    localparam int BIT_DIR    = 2;
    localparam int BIT_IRQ    = 1;
    localparam int BIT_RXACK  = 0;
    // ------------------------------------------------------------
    // Options register field positions
    // ------------------------------------------------------------
    localparam int OPT_RANGE_MATCH_ENABLE   = 0;
    localparam int OPT_GCEN   = 1;
    localparam int OPT_SAEN   = 2;
    localparam int OPT_ALEN   = 3;
    localparam int OPT_FAST_ACK_ENABLE   = 4;
    localparam int OPT_START_STOP_IRQ_ENABLE   = 5;
    localparam int OPT_TX     = 6;
    localparam int OPT_ACKV   = 7;
    // ------------------------------------------------------------
    // Event register field positions and widths
    // ------------------------------------------------------------
    localparam int EV_ADDR    = 0;
    localparam int EV_DONE    = 1;
    localparam int EV_ARBITRATION_LOST_FLAG    = 2;
    localparam int EV_BUSY    = 3;
    localparam int EV_W       = 4;
    // ------------------------------------------------------------
    // Fixed addresses and reset values
    // ------------------------------------------------------------
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [6:0] ALERT_RESP_ADDR   = 7'h0c;
    localparam logic [7:0] STATUS_RESET      = 8'h80;
    localparam logic [7:0] BYTE_RESET        = 8'h00;
endpackage

// ### dv/i2csf_bus_model.sv
// Bus-side model that drives link events toward the status flag block
`timescale 1ns/10ps
module i2csf_bus_model
(
    input  wire logic       clk_sys_i,
    output logic            addr_valid_o,
    output logic      [6:0] addr_rx_o,
    output logic            addr_rw_o,
    output logic      [5:0] ev_o,
    output logic            ack_seen_o,
    output logic            ssf_o,
    output logic            slave_rx_o
);
    // Idle state; event bits: byte end, ack end, arb lost, start, stop, timeout
    initial
    begin
        addr_valid_o = 1'b0;
        addr_rx_o    = 7'h55;
        addr_rw_o    = 1'b0;
        ev_o         = 6'h00;
        ack_seen_o   = 1'b1;
        ssf_o        = 1'b0;
        slave_rx_o   = 1'b0;
    end
    // Address byte, offered ahead of its ack slot
    task automatic send_addr(input logic [6:0] a, input logic rw);
        @(posedge clk_sys_i);
        addr_valid_o <= 1'b1;
        addr_rx_o    <= a;
        addr_rw_o    <= rw;
        @(posedge clk_sys_i);
        addr_valid_o <= 1'b0;
        addr_rx_o    <= ~a;   // Released lines never keep the last value
        addr_rw_o    <= ~rw;
    endtask
    // One-cycle event pulse
    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        ev_o[k] <= 1'b1;
        @(posedge clk_sys_i);
        ev_o[k] <= 1'b0;
    endtask
    // Level lines: ack on the wire, start/stop flag, receiving a byte
    task automatic levels(input logic ack, input logic ssf, input logic rx);
        @(posedge clk_sys_i);
        ack_seen_o <= ack;
        ssf_o      <= ssf;
        slave_rx_o <= rx;
    endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the status flag block
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [7:0] opt; logic [6:0] a1; logic [6:0] ra; logic [6:0] sa;
        logic [6:0] ad; logic rw; logic [7:0] exp;} i2csf_row_s;
    logic        clk_sys_i;
    logic        arst_n_i;
    logic        clk_en;
    logic [3:0]  be;
    logic [3:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        a_valid;
    logic [6:0]  a_rx;
    logic        a_rw;
    logic [5:0]  ev;
    logic        ack_seen;
    logic        ssf;
    logic        srx;
    logic [2:0]  outs;
    int          n_mismatch;
    int          tests_run;
    i2csf_row_s  rows [12];
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    i2csf_status i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en),
        .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wdata), .avs_byteenable_i(be), .avs_readdata_o(av_rdata),
        .avs_waitrequest_o(av_wait), .addr_valid_i(a_valid), .addr_rx_i(a_rx),
        .addr_rw_i(a_rw), .byte_end_i(ev[0]), .ack_end_i(ev[1]), .ack_seen_i(ack_seen),
        .arb_lost_i(ev[2]), .start_det_i(ev[3]), .stop_det_i(ev[4]), .timeout_i(ev[5]),
        .start_stop_flag_i(ssf), .slave_rx_i(srx), .ack_drive_o(outs[1]),
        .ack_value_o(outs[2]), .irq_o(outs[0]));
    i2csf_bus_model i_bus (.clk_sys_i(clk_sys_i), .addr_valid_o(a_valid), .addr_rx_o(a_rx),
        .addr_rw_o(a_rw), .ev_o(ev), .ack_seen_o(ack_seen), .ssf_o(ssf), .slave_rx_o(srx));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One Avalon transfer; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        av_addr  <= idx;
        av_wdata <= {24'h000000, wd};
        av_wr    <= w;
        av_rd    <= ~w;
        @(posedge clk_sys_i);
        while (av_wait !== 1'b0 && n < 20)
        begin
            n++;
            @(posedge clk_sys_i);
        end
        if (av_wait !== 1'b0)
        begin
            n_mismatch++;
            report_and_stop();
        end
        rd = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask
    // Read and compare masked bits; upper lanes must always read zero
    task automatic chk(input logic [3:0] idx, input logic [7:0] e, input logic [7:0] m);
        logic [31:0] x;
        bus(1'b0, idx, 8'h00, x);
        tests_run++;
        if ((x & {24'hffffff, m}) !== {24'h000000, e & m})
            $display("Error at %0t: got %h expected %h", $time, x, e & m);
        if ((x & {24'hffffff, m}) !== {24'h000000, e & m})
            n_mismatch++;
    endtask
    // Output pin check: 0 irq, 1 ack drive, 2 ack value
    task automatic pin(input int k, input logic e);
        @(negedge clk_sys_i);
        tests_run++;
        if (outs[k] !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, outs[k], e);
        end
    endtask
    // ------------------------------------------------------------
    // Clock, reset and sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Rows: options, primary, range, second, address, rw, expected status bits
    initial
    begin
        rows = '{'{8'h00, 7'h10, 7'h00, 7'h00, 7'h10, 1'b0, 8'h42},
                 '{8'h00, 7'h10, 7'h00, 7'h00, 7'h11, 1'b1, 8'h00},
                 '{8'h01, 7'h10, 7'h20, 7'h00, 7'h20, 1'b1, 8'h4e},
                 '{8'h01, 7'h10, 7'h20, 7'h00, 7'h18, 1'b0, 8'h4a},
                 '{8'h00, 7'h10, 7'h20, 7'h00, 7'h20, 1'b0, 8'h00},
                 '{8'h01, 7'h10, 7'h00, 7'h00, 7'h00, 1'b0, 8'h00},
                 '{8'h02, 7'h10, 7'h00, 7'h00, 7'h00, 1'b0, 8'h42},
                 '{8'h04, 7'h10, 7'h00, 7'h33, 7'h33, 1'b1, 8'h46},
                 '{8'h08, 7'h10, 7'h00, 7'h00, 7'h0c, 1'b0, 8'h42},
                 '{8'h00, 7'h10, 7'h00, 7'h00, 7'h0c, 1'b0, 8'h00},
                 '{8'h01, 7'h10, 7'h20, 7'h00, 7'h21, 1'b0, 8'h00},
                 '{8'h01, 7'h20, 7'h10, 7'h00, 7'h15, 1'b1, 8'h4e}};
        n_mismatch = 0;
        tests_run  = 0;
        av_addr    = 4'h0;
        av_rd      = 1'b0;
        av_wr      = 1'b0;
        av_wdata   = 32'h00000000;
        clk_en     = 1'b1;
        be         = 4'h1;
        arst_n_i   = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk(i2csf_pkg::IDX_STATUS, i2csf_pkg::STATUS_RESET, 8'hff);
        chk(4'hf, 8'h00, 8'hff);
        foreach (rows[i])
        begin
            wr(i2csf_pkg::IDX_ADDR1, {rows[i].a1, 1'b0});
            wr(i2csf_pkg::IDX_RANGE, {rows[i].ra, 1'b0});
            wr(i2csf_pkg::IDX_SECOND, {rows[i].sa, 1'b0});
            wr(i2csf_pkg::IDX_OPTIONS, rows[i].opt);
            wr(i2csf_pkg::IDX_CTRL1, 8'h00);
            wr(i2csf_pkg::IDX_STATUS, 8'h02);
            i_bus.send_addr(rows[i].ad, rows[i].rw);
            chk(i2csf_pkg::IDX_STATUS, rows[i].exp, rows[i].exp[6] ? 8'h4e : 8'h4a);
        end
        wr(i2csf_pkg::IDX_CTRL1, 8'hff);
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h48);
        // Receive byte with fast ack off, then on
        wr(i2csf_pkg::IDX_OPTIONS, 8'h80);
        i_bus.levels(1'b1, 1'b0, 1'b1);
        pin(2, 1'b1);
        pin(1, 1'b1);
        wr(i2csf_pkg::IDX_STATUS, 8'h02);
        i_bus.pulse(0);
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h82);
        i_bus.pulse(1);
        chk(i2csf_pkg::IDX_STATUS, 8'h82, 8'h82);
        chk(i2csf_pkg::IDX_DATA, 8'h00, 8'h00);
        chk(i2csf_pkg::IDX_STATUS, 8'h02, 8'h82);
        wr(i2csf_pkg::IDX_STATUS, 8'h02);
        wr(i2csf_pkg::IDX_OPTIONS, 8'h10);
        i_bus.pulse(0);
        chk(i2csf_pkg::IDX_STATUS, 8'h02, 8'h82);
        // Transmit byte answered by no ack
        wr(i2csf_pkg::IDX_OPTIONS, 8'h40);
        i_bus.levels(1'b0, 1'b0, 1'b0);
        pin(1, 1'b0);
        pin(2, 1'b0);
        i_bus.pulse(1);
        chk(i2csf_pkg::IDX_STATUS, 8'h81, 8'h81);
        wr(i2csf_pkg::IDX_DATA, 8'h5a);
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h80);
        i_bus.levels(1'b1, 1'b0, 1'b0);
        i_bus.pulse(1);
        chk(i2csf_pkg::IDX_STATUS, 8'h80, 8'h81);
        // Busy, arbitration, masking and clearing of the interrupt line
        i_bus.pulse(3);
        chk(i2csf_pkg::IDX_STATUS, 8'h20, 8'h20);
        i_bus.pulse(4);
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h20);
        // Clock enable low freezes the flags, so a start is missed
        clk_en <= 1'b0;
        i_bus.pulse(3);
        clk_en <= 1'b1;
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h20);
        wr(i2csf_pkg::IDX_EVMASK, 8'h04);
        wr(i2csf_pkg::IDX_STATUS, 8'h02);
        i_bus.pulse(2);
        pin(0, 1'b1);
        wr(i2csf_pkg::IDX_STATUS, 8'hec);
        chk(i2csf_pkg::IDX_STATUS, 8'h12, 8'h12);
        wr(i2csf_pkg::IDX_EVMASK, 8'h00);
        pin(0, 1'b0);
        wr(i2csf_pkg::IDX_EVMASK, 8'h04);
        wr(i2csf_pkg::IDX_EVSTAT, 8'h04);
        pin(0, 1'b0);
        wr(i2csf_pkg::IDX_STATUS, 8'h12);
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h12);
        i_bus.pulse(5);
        chk(i2csf_pkg::IDX_STATUS, 8'h02, 8'h02);
        // A write without lane zero must not clear anything
        be <= 4'h0;
        wr(i2csf_pkg::IDX_STATUS, 8'h02);
        be <= 4'h1;
        chk(i2csf_pkg::IDX_STATUS, 8'h02, 8'h02);
        wr(i2csf_pkg::IDX_STATUS, 8'h02);
        // Start/stop interrupt: flag cleared before the pending bit
        wr(i2csf_pkg::IDX_OPTIONS, 8'h20);
        i_bus.levels(1'b0, 1'b1, 1'b0);
        chk(i2csf_pkg::IDX_STATUS, 8'h02, 8'h02);
        i_bus.levels(1'b0, 1'b0, 1'b0);
        wr(i2csf_pkg::IDX_STATUS, 8'h02);
        chk(i2csf_pkg::IDX_STATUS, 8'h00, 8'h02);
        // Reset in mid-run with the bus busy
        i_bus.pulse(3);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk(i2csf_pkg::IDX_STATUS, i2csf_pkg::STATUS_RESET, 8'hff);
        pin(0, 1'b0);
        report_and_stop();
    end
endmodule

// ### src/i2csf_status.sv
// Status flag logic of a two-wire bus controller with an Avalon-MM register slave
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Contract
// - Byte-done flag bit 7 sets when a byte transfer finishes.
// - Byte-done clears on data read in receive, data write in transmit.
// - Addressed flag sets on primary match or nonzero range match with range enabled.
// - Addressed also on enabled general call, second address, alert response.
// - Addressed when range enabled and address lies between primary and range.
// - Addressed flag is set before the address acknowledge bit.
// - Any control one write clears addressed and range-match flags; here only with byte lane 0, and a same-cycle match wins.
// - Busy flag sets on START, clears on STOP, any mode.
// - Arbitration-lost sets on loss, clears only by writing one.
// - Range-match flag sets on nonzero range equal or in-range address.
// - Direction bit shows received read/write bit when addressed.
// - Interrupt-pending flag sets on events, stays until written one.
// - Byte-done interrupt after ack with fast ack off, before with on.
// - Software writes ack control in receive; device sends ACK or NACK.
// - Interrupt also on address match, arbitration loss, timeouts, start/stop; timeouts set the pending flag only, never irq_o.
// - Received-ack bit 0 shows acknowledge after a transmitted byte.
module i2csf_status
(
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        clk_en_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        addr_valid_i,
    input  wire logic [6:0]  addr_rx_i,
    input  wire logic        addr_rw_i,
    input  wire logic        byte_end_i,
    input  wire logic        ack_end_i,
    input  wire logic        ack_seen_i,
    input  wire logic        arb_lost_i,
    input  wire logic        start_det_i,
    input  wire logic        stop_det_i,
    input  wire logic        timeout_i,
    input  wire logic        start_stop_flag_i,
    input  wire logic        slave_rx_i,
    output logic             ack_drive_o,
    output logic             ack_value_o,
    output logic             irq_o
);
    // ------------------------------------------------------------
    // Reset release and local state
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;
    logic [7:0] status_r;
    logic [7:0] options_r;
    logic [6:0] primary_slave_address_r;
    logic [6:0] range_slave_address_r;
    logic [6:0] second_address_r;
    logic [i2csf_pkg::EV_W-1:0] ev_stat_r;
    logic [i2csf_pkg::EV_W-1:0] ev_mask_r;
    logic       rd_ack_r;
    logic [31:0] rdata_r;

    // Two-flop release so deassertion never lands mid-setup
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic acc_en;
    logic wr_go;
    logic rd_go;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic range_en;
    logic tx_mode;
    logic fast_ack;

    // Reads take one wait cycle; writes complete at once
    assign acc_en   = clk_en_i && rst_n;
    assign wr_go    = acc_en && avs_write_i;
    assign rd_go    = acc_en && avs_read_i && rd_ack_r;
    assign wr_lane0 = wr_go && avs_byteenable_i[0];
    assign wbyte    = avs_writedata_i[7:0];
    assign avs_waitrequest_o = avs_read_i && !rd_ack_r;
    assign range_en = options_r[i2csf_pkg::OPT_RANGE_MATCH_ENABLE];
    assign tx_mode  = options_r[i2csf_pkg::OPT_TX];
    assign fast_ack = options_r[i2csf_pkg::OPT_FAST_ACK_ENABLE];

    // ------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------
    logic prim_hit;
    logic range_eq;
    logic range_in;
    logic range_hit;
    logic other_hit;
    logic addr_hit;
    logic [6:0] lo_addr;
    logic [6:0] hi_addr;

    // Range bounds ordered so either register may hold the lower value
    always_comb
    begin
        if (primary_slave_address_r <= range_slave_address_r)
        begin
            lo_addr = primary_slave_address_r;
            hi_addr = range_slave_address_r;
        end
        else
        begin
            lo_addr = range_slave_address_r;
            hi_addr = primary_slave_address_r;
        end
    end

    // Match terms, all combinational so the flag rises before the ack slot
    assign prim_hit  = addr_rx_i == primary_slave_address_r;
    assign range_eq  = (range_slave_address_r != 7'h00)
                       && (addr_rx_i == range_slave_address_r);
    assign range_in  = (addr_rx_i != 7'h00) && (addr_rx_i >= lo_addr)
                       && (addr_rx_i <= hi_addr);
    assign range_hit = range_en && (range_eq || range_in);
    assign other_hit = (options_r[i2csf_pkg::OPT_GCEN]
                        && addr_rx_i == i2csf_pkg::GENERAL_CALL_ADDR)
                    || (options_r[i2csf_pkg::OPT_SAEN] && addr_rx_i == second_address_r)
                    || (options_r[i2csf_pkg::OPT_ALEN]
                        && addr_rx_i == i2csf_pkg::ALERT_RESP_ADDR);
    assign addr_hit  = addr_valid_i && (prim_hit || range_hit || other_hit);

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic ctrl1_wr;
    logic data_rd;
    logic data_wr;
    logic status_wr;
    logic done_irq_ev;
    logic irq_set;

    assign ctrl1_wr  = wr_lane0 && avs_address_i == i2csf_pkg::IDX_CTRL1;
    assign status_wr = wr_lane0 && avs_address_i == i2csf_pkg::IDX_STATUS;
    assign data_wr   = wr_lane0 && avs_address_i == i2csf_pkg::IDX_DATA;
    assign data_rd   = rd_go && avs_address_i == i2csf_pkg::IDX_DATA;
    // Byte interrupt timing follows the fast ack option
    assign done_irq_ev = fast_ack ? byte_end_i : ack_end_i;
    assign irq_set   = done_irq_ev || addr_hit || arb_lost_i || timeout_i
                    || (options_r[i2csf_pkg::OPT_START_STOP_IRQ_ENABLE] && start_stop_flag_i);

    // Byte-done: set wins over a same-cycle clear
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            status_r[i2csf_pkg::BIT_DONE] <= i2csf_pkg::STATUS_RESET[i2csf_pkg::BIT_DONE];
        else if (acc_en)
        begin
            if (ack_end_i || byte_end_i)
                status_r[i2csf_pkg::BIT_DONE] <= ack_end_i;
            else if ((data_rd && !tx_mode) || (data_wr && tx_mode))
                status_r[i2csf_pkg::BIT_DONE] <= 1'b0;
        end
    end

    // Addressed and range-match flags, cleared by a control one write with byte lane 0 unless a same-cycle match sets them
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            status_r[i2csf_pkg::BIT_ADDRD] <= 1'b0;
            status_r[i2csf_pkg::BIT_RANGE] <= 1'b0;
            status_r[i2csf_pkg::BIT_DIR]   <= 1'b0;
        end
        else if (acc_en)
        begin
            if (addr_hit)
            begin
                status_r[i2csf_pkg::BIT_ADDRD] <= 1'b1;
                status_r[i2csf_pkg::BIT_DIR]   <= addr_rw_i;
            end
            else if (ctrl1_wr)
                status_r[i2csf_pkg::BIT_ADDRD] <= 1'b0;
            if (addr_valid_i && range_hit)
                status_r[i2csf_pkg::BIT_RANGE] <= 1'b1;
            else if (ctrl1_wr)
                status_r[i2csf_pkg::BIT_RANGE] <= 1'b0;
        end
    end

    // Busy, arbitration, interrupt and ack flags
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            status_r[i2csf_pkg::BIT_BUSY]  <= 1'b0;
            status_r[i2csf_pkg::BIT_ARBITRATION_LOST_FLAG]  <= 1'b0;
            status_r[i2csf_pkg::BIT_IRQ]   <= 1'b0;
            status_r[i2csf_pkg::BIT_RXACK] <= 1'b0;
        end
        else if (acc_en)
        begin
            if (start_det_i)
                status_r[i2csf_pkg::BIT_BUSY] <= 1'b1;
            else if (stop_det_i)
                status_r[i2csf_pkg::BIT_BUSY] <= 1'b0;
            if (arb_lost_i)
                status_r[i2csf_pkg::BIT_ARBITRATION_LOST_FLAG] <= 1'b1;
            else if (status_wr && wbyte[i2csf_pkg::BIT_ARBITRATION_LOST_FLAG])
                status_r[i2csf_pkg::BIT_ARBITRATION_LOST_FLAG] <= 1'b0;
            if (irq_set)
                status_r[i2csf_pkg::BIT_IRQ] <= 1'b1;
            else if (status_wr && wbyte[i2csf_pkg::BIT_IRQ])
                status_r[i2csf_pkg::BIT_IRQ] <= 1'b0;
            if (ack_end_i && tx_mode)
                status_r[i2csf_pkg::BIT_RXACK] <= !ack_seen_i;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            options_r               <= i2csf_pkg::BYTE_RESET;
            primary_slave_address_r <= 7'h00;
            range_slave_address_r   <= 7'h00;
            second_address_r        <= 7'h00;
            ev_mask_r               <= '0;
        end
        else if (wr_lane0)
        begin
            unique case (avs_address_i)
                i2csf_pkg::IDX_OPTIONS: options_r               <= wbyte;
                i2csf_pkg::IDX_ADDR1:   primary_slave_address_r <= wbyte[7:1];
                i2csf_pkg::IDX_RANGE:   range_slave_address_r   <= wbyte[7:1];
                i2csf_pkg::IDX_SECOND:  second_address_r        <= wbyte[7:1];
                i2csf_pkg::IDX_EVMASK:  ev_mask_r <= wbyte[i2csf_pkg::EV_W-1:0];
                default:                ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Event interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    logic [i2csf_pkg::EV_W-1:0] ev_in;
    logic evstat_wr;

    assign ev_in = {start_det_i || stop_det_i, arb_lost_i, done_irq_ev, addr_hit};
    assign evstat_wr = wr_lane0 && avs_address_i == i2csf_pkg::IDX_EVSTAT;

    generate
        for (genvar g = 0; g < i2csf_pkg::EV_W; g++)
        begin : g_ev
            always_ff @(posedge clk_sys_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                    ev_stat_r[g] <= 1'b0;
                else if (acc_en)
                begin
                    if (ev_in[g])
                        ev_stat_r[g] <= 1'b1;
                    else if (evstat_wr && wbyte[g])
                        ev_stat_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt while any unmasked event is pending
    assign irq_o = |(ev_stat_r & ev_mask_r);

    // Ack drive in receive mode uses the software ack value
    assign ack_drive_o = slave_rx_i && !tx_mode;
    assign ack_value_o = options_r[i2csf_pkg::OPT_ACKV];

    // ------------------------------------------------------------
    // Read path, one wait state so data come from a flop
    // ------------------------------------------------------------
    logic [7:0] rmux;

    // Status read returns live flags; a data write in transmit mode clears byte-done
    always_comb
    begin
        rmux = 8'h00;
        unique case (avs_address_i)
            i2csf_pkg::IDX_STATUS:  rmux = status_r;
            i2csf_pkg::IDX_OPTIONS: rmux = options_r;
            i2csf_pkg::IDX_ADDR1:   rmux = {primary_slave_address_r, 1'b0};
            i2csf_pkg::IDX_RANGE:   rmux = {range_slave_address_r, 1'b0};
            i2csf_pkg::IDX_SECOND:  rmux = {second_address_r, 1'b0};
            i2csf_pkg::IDX_EVSTAT:  rmux = {4'h0, ev_stat_r};
            i2csf_pkg::IDX_EVMASK:  rmux = {4'h0, ev_mask_r};
            default:                rmux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_ack_r <= 1'b0;
            rdata_r  <= 32'h0;
        end
        else if (acc_en)
        begin
            rd_ack_r <= avs_read_i && !rd_ack_r;
            rdata_r  <= {24'h0, rmux};
        end
    end
    assign avs_readdata_o = rdata_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_busy_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        clk_en_i && start_det_i |=> status_r[i2csf_pkg::BIT_BUSY])
        else $error("busy not set after start");
    a_busy_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        clk_en_i && stop_det_i && !start_det_i |=> !status_r[i2csf_pkg::BIT_BUSY])
        else $error("busy not cleared after stop");
    a_arbitration_lost_flag_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $fell(status_r[i2csf_pkg::BIT_ARBITRATION_LOST_FLAG]) |-> $past(status_wr && wbyte[4]))
        else $error("arbitration flag cleared without write one");
    a_arbitration_lost_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        clk_en_i && arb_lost_i |=> status_r[i2csf_pkg::BIT_ARBITRATION_LOST_FLAG] && status_r[1])
        else $error("arbitration loss not flagged");
    a_addr_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        clk_en_i && addr_hit |=> status_r[i2csf_pkg::BIT_ADDRD]
        && status_r[i2csf_pkg::BIT_DIR] == $past(addr_rw_i))
        else $error("addressed flag or direction wrong");
    a_ctrl_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        ctrl1_wr && !addr_valid_i |=> !status_r[6] && !status_r[3])
        else $error("control one write did not clear flags");
    a_irq_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $fell(status_r[i2csf_pkg::BIT_IRQ]) |-> $past(status_wr && wbyte[1]))
        else $error("interrupt flag cleared without write one");
    a_done_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        data_wr && tx_mode && !byte_end_i && !ack_end_i |=> !status_r[7])
        else $error("byte done not cleared by transmit write");
    a_fast_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        clk_en_i && fast_ack && byte_end_i |=> status_r[i2csf_pkg::BIT_IRQ])
        else $error("fast ack interrupt missing");
    a_read_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        avs_read_i && clk_en_i && !rd_ack_r |=> !avs_waitrequest_o || !avs_read_i)
        else $error("read not answered in one cycle");

    c_addressed: cover property (@(posedge clk_sys_i) disable iff (!rst_n) addr_hit);
    c_range: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        addr_valid_i && range_in && !prim_hit);
    c_arb_irq: cover property (@(posedge clk_sys_i) disable iff (!rst_n) arb_lost_i ##1 irq_o);
    c_busy_cycle: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        start_det_i ##[1:20] stop_det_i);
endmodule
